// File: verilog/qdsl_pkg.sv
package qdsl_pkg;
    // widths of the frame and the channel codes
    localparam int CODE_W     = 14;
    localparam int FRAME_W    = 16;
    localparam int CHAIN_W    = 19;
    localparam int NUM_CH     = 4;
    localparam int ADDR_HI    = 15;
    localparam int ADDR_LO    = 14;
    localparam int CODE_MSB   = 13;
    localparam int SYNC_W     = 3;
    // cycles of power-on preset after reset, long enough for the level pin to pass its synchroniser
    localparam logic [2:0] POR_CYC = 3'h4;
    // preset values
    localparam logic [13:0] CODE_ZERO = 14'h0000;
    localparam logic [13:0] CODE_HALF = 14'h2000;

    // raw pins from the serial host, synchronised inside qdsl_serial_load
    typedef struct packed {
        logic chipSel_n;
        logic serialClk;
        logic serialIn;
    } qdsl_link_t;

    // control pins
    typedef struct packed {
        logic preset_n;
        logic presetHalf;
        logic update_strobe_n;
    } qdsl_ctrl_t;

    // whole state of the top module
    typedef struct packed {
        logic [2:0]               csSync;
        logic [2:0]               clkSync;
        logic [2:0]               dinSync;
        logic [2:0]               prSync;
        logic [2:0]               halfSync;
        logic [2:0]               updSync;
        logic                     csLevel;
        logic                     clkLevel;
        logic [2:0]               porCnt;
        logic [18:0]              shiftReg;
        logic                     chainOut;
        logic [3:0][13:0]         inputCode;
        logic [3:0][13:0]         convCode;
        logic                     loadPulse;
    } qdsl_state_t;
endpackage : qdsl_pkg

// File: verilog/qdsl_serial_load.sv
`timescale 1ns/100ps
module qdsl_serial_load (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // serial link from the host
    input  wire qdsl_pkg::qdsl_link_t   link,
    // control pins
    input  wire qdsl_pkg::qdsl_ctrl_t   ctrl,
    // outputs
    output logic                        serial_chain_out,
    output logic [3:0][13:0]            channelCode,
    output logic                        loadDone
);
    import qdsl_pkg::*;

    qdsl_state_t r;
    qdsl_state_t next_r;

    logic        csAgree;
    logic        clkAgree;
    logic        csLow;
    logic        csRise;
    logic        clkRise;
    logic        porBusy;
    logic        presetOn;
    logic        halfSel;
    logic [13:0] presetCode;
    logic [1:0]  addrSel;

    // a chip select or link clock change counts once the second and third stages agree
    always_comb begin
        csAgree    = (r.csSync[2] == r.csSync[1]);
        clkAgree   = (r.clkSync[2] == r.clkSync[1]);
        csLow      = csAgree && !r.csSync[2];
        csRise     = csAgree && r.csSync[2] && !r.csLevel;
        clkRise    = clkAgree && r.clkSync[2] && !r.clkLevel;
        porBusy    = (r.porCnt != 3'h0);
        presetOn   = (r.prSync[2:1] == 2'b00) || porBusy;
        halfSel    = r.halfSync[2];
        presetCode = halfSel ? CODE_HALF : CODE_ZERO;
        addrSel    = {r.shiftReg[ADDR_HI], r.shiftReg[ADDR_LO]};
    end

    // next state
    always_comb begin
        next_r = r;
        next_r.csSync   = {r.csSync[1:0], link.chipSel_n};
        next_r.clkSync  = {r.clkSync[1:0], link.serialClk};
        next_r.dinSync  = {r.dinSync[1:0], link.serialIn};
        next_r.prSync   = {r.prSync[1:0], ctrl.preset_n};
        next_r.halfSync = {r.halfSync[1:0], ctrl.presetHalf};
        next_r.updSync  = {r.updSync[1:0], ctrl.update_strobe_n};
        next_r.loadPulse = 1'b0;
        // agreed pin levels, so each edge is seen exactly once
        if (csAgree) begin
            next_r.csLevel = r.csSync[2];
        end
        if (clkAgree) begin
            next_r.clkLevel = r.clkSync[2];
        end
        // power-on preset runs until the level pin has passed its synchroniser
        if (porBusy) begin
            next_r.porCnt = r.porCnt - 3'h1;
        end
        // shift only on a clock rise with chip select low
        if (csLow && clkRise) begin
            next_r.shiftReg = {r.shiftReg[17:0], r.dinSync[2]};
            next_r.chainOut = r.shiftReg[CHAIN_W-1];
        end
        // addressed load on chip select rise, from the last 16 bits
        if (csRise) begin
            next_r.inputCode[addrSel] = r.shiftReg[CODE_MSB:0];
            next_r.loadPulse = 1'b1;
        end
        // transparent converter registers while the strobe is low
        if (r.updSync[2:1] == 2'b00) begin
            next_r.convCode = next_r.inputCode;
        end
        // preset overrides any load in the same cycle
        if (presetOn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                next_r.inputCode[i] = presetCode;
                next_r.convCode[i]  = presetCode;
            end
            next_r.loadPulse = 1'b0;
        end
    end

    // register the state; reset loads constants only, the level pin is applied by the
    // power-on preset counter once it has been synchronised
    always_ff @(posedge clk) begin
        if (srst) begin
            r         <= '0;
            r.csSync  <= 3'h7;
            r.prSync  <= 3'h7;
            r.updSync <= 3'h7;
            r.csLevel <= 1'b1;
            r.porCnt  <= POR_CYC;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flip-flops, four 14-bit codes
    assign serial_chain_out = r.chainOut;
    assign channelCode      = r.convCode;
    assign loadDone         = r.loadPulse;

    // assertions
    a_shift_gated: assert property (@(posedge clk) disable iff (srst)
        !(csLow && clkRise) |=> $stable(r.shiftReg))
        else $error("shift register moved without a gated clock rise");
    a_shift_in: assert property (@(posedge clk) disable iff (srst)
        (csLow && clkRise) |=> r.shiftReg[0] == $past(r.dinSync[2]))
        else $error("shifted bit does not match serial input");
    a_chain_delay: assert property (@(posedge clk) disable iff (srst)
        (csLow && clkRise) |=> r.chainOut == $past(r.shiftReg[18]))
        else $error("chain output not 19 pulses behind");
    a_load_addr: assert property (@(posedge clk) disable iff (srst)
        (csRise && !presetOn) |=>
        r.inputCode[$past(addrSel)] == $past(r.shiftReg[13:0]))
        else $error("addressed channel not loaded");
    a_load_chan_a: assert property (@(posedge clk) disable iff (srst)
        (csRise && !presetOn && addrSel == 2'b00) |=>
        r.inputCode[0] == $past(r.shiftReg[13:0]) && $stable(r.inputCode[3]))
        else $error("address 00 did not pick channel A");
    a_preset_hold: assert property (@(posedge clk) disable iff (srst)
        presetOn |=> r.convCode[2] == $past(presetCode) && !r.loadPulse)
        else $error("preset value not forced");
    a_preset_wins: assert property (@(posedge clk) disable iff (srst)
        (presetOn && csRise) |=> r.inputCode[1] == $past(presetCode))
        else $error("load beat preset");
    a_latched_conv: assert property (@(posedge clk) disable iff (srst)
        (r.updSync[2:1] != 2'b00 && !presetOn) |=> $stable(r.convCode))
        else $error("converter registers moved while latched");
    a_transparent: assert property (@(posedge clk) disable iff (srst)
        (r.updSync[2:1] == 2'b00 && !presetOn && !csRise) |=>
        r.convCode == r.inputCode)
        else $error("converter registers not transparent");
    // power-on preset and preset level
    a_por_hold: assert property (@(posedge clk) disable iff (srst)
        porBusy |=> r.inputCode[0] == $past(presetCode))
        else $error("power-on preset not applied");
    a_half_level: assert property (@(posedge clk) disable iff (srst)
        (presetOn && halfSel) |=> r.convCode[0] == CODE_HALF)
        else $error("half-scale preset not applied");
    // input registers only move on an accepted load or a preset
    a_load_pulse: assert property (@(posedge clk) disable iff (srst)
        r.loadPulse |-> $past(csRise) && !$past(presetOn))
        else $error("load pulse without an accepted load");
    a_code_stays: assert property (@(posedge clk) disable iff (srst)
        (!csRise && !presetOn) |=> $stable(r.inputCode))
        else $error("input registers moved without a load");
    // each link clock rise shifts once, never while deselected
    a_clk_once: assert property (@(posedge clk) disable iff (srst)
        clkRise |=> !clkRise)
        else $error("one link clock rise seen twice");
    a_cs_high_idle: assert property (@(posedge clk) disable iff (srst)
        !csLow |=> $stable(r.shiftReg))
        else $error("shift register moved while deselected");
    a_chain_idle: assert property (@(posedge clk) disable iff (srst)
        !(csLow && clkRise) |=> $stable(r.chainOut))
        else $error("chain output moved without a shift");
    // address decode for the remaining channels
    a_load_chan_b: assert property (@(posedge clk) disable iff (srst)
        (csRise && !presetOn && addrSel == 2'b01) |=>
        r.inputCode[1] == $past(r.shiftReg[13:0]) && $stable(r.inputCode[0]))
        else $error("address 01 did not pick channel B");
    a_load_chan_c: assert property (@(posedge clk) disable iff (srst)
        (csRise && !presetOn && addrSel == 2'b10) |=>
        r.inputCode[2] == $past(r.shiftReg[13:0]) && $stable(r.inputCode[1]))
        else $error("address 10 did not pick channel C");
    a_load_chan_d: assert property (@(posedge clk) disable iff (srst)
        (csRise && !presetOn && addrSel == 2'b11) |=>
        r.inputCode[3] == $past(r.shiftReg[13:0]) && $stable(r.inputCode[2]))
        else $error("address 11 did not pick channel D");
    // main scenarios
    c_load: cover property (@(posedge clk) disable iff (srst) csRise && !presetOn);
    c_por: cover property (@(posedge clk) disable iff (srst) porBusy ##1 !porBusy);
    c_chain: cover property (@(posedge clk) disable iff (srst) $rose(r.chainOut));
    c_preset: cover property (@(posedge clk) disable iff (srst) presetOn ##1 !presetOn);
    c_update: cover property (@(posedge clk) disable iff (srst)
        r.updSync[2:1] == 2'b00 && csRise);
endmodule : qdsl_serial_load

// File: test/qdsl_host_model.sv
`timescale 1ns/100ps
// serial host: 24- or 16-bit frames, msb first, link clock idles low between frames
module qdsl_host_model (
    // system clock paces the link
    input  wire logic            clk,
    // pins towards the converter
    output qdsl_pkg::qdsl_link_t link
);
    import qdsl_pkg::*;
    // idle: deselected, clock still
    initial begin
        link = 3'b100;
    end
    // wait a number of system clock edges
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks
    // 24 or 16 right-justified bits under one chip select, 160 ns link clock
    task automatic send(input logic [23:0] frame, input int nbits = 24);
        @(posedge clk);
        link.chipSel_n <= 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            link.serialIn <= frame[i];
            ticks(8);
            link.serialClk <= 1'b1;
            ticks(8);
            link.serialClk <= 1'b0;
        end
        ticks(8);
        link.chipSel_n <= 1'b1;
        link.serialIn  <= ~frame[0]; // released line shows no stale value
    endtask : send
endmodule : qdsl_host_model

// File: test/qdsl_serial_load_tb_top.sv
`timescale 1ns/100ps
// bench: host model on the link, control pins driven here
module qdsl_serial_load_tb_top;
    import qdsl_pkg::*;
    logic             clk = 1'b0;
    logic             srst = 1'b1;
    qdsl_ctrl_t       ctrl = 3'b111;
    qdsl_link_t       link;
    logic             chainOut;
    logic [3:0][13:0] code;
    logic [3:0][13:0] exp;
    logic             loadDone;
    int               numErrors = 0;
    int               cmpCount = 0;
    qdsl_host_model i_host (.clk(clk), .link(link));
    qdsl_serial_load i_dut (.clk(clk), .srst(srst), .link(link), .ctrl(ctrl),
        .serial_chain_out(chainOut), .channelCode(code), .loadDone(loadDone));
    // free-running system clock
    initial begin
        forever #5 clk = ~clk;
    end
    // one comparison
    task automatic check(input string what, input logic [13:0] e, input logic [13:0] g);
        cmpCount++;
        if (g !== e) begin
            numErrors++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : check
    // verdict and end of run
    task automatic endSim;
        $display("comparisons %0d, mismatches %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : endSim
    // all four channel codes
    task automatic checkAll;
        for (int c = 0; c < NUM_CH; c++) begin
            check("channel code", exp[c], code[c]);
        end
    endtask : checkAll
    // one frame with junk leading byte, then bounded wait for the load pulse
    task automatic load(input logic [1:0] ch, input logic [13:0] val, input int nbits = 24);
        int n;
        n = 0;
        i_host.send({8'h5a, ch, val}, nbits);
        while (loadDone !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 40) begin
                numErrors++;
                endSim();
            end
        end
        repeat (2) @(negedge clk);
    endtask : load
    // every address lands in its own channel while the strobe is low
    task automatic s_channels;
        @(posedge clk) ctrl.update_strobe_n <= 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            exp[c] = 14'h3ffc + 14'(c);
            load(2'(c), exp[c]);
            checkAll();
        end
        exp[0] = 14'h1234;
        load(2'h0, exp[0], 16);
        checkAll();
    endtask : s_channels
    // strobe high holds outputs, then moves both channels together
    task automatic s_strobe;
        @(posedge clk) ctrl.update_strobe_n <= 1'b1;
        load(2'h1, 14'h0155);
        load(2'h2, 14'h2aaa);
        checkAll();
        check("chain out", 14'h0001, {13'h0000, chainOut});
        @(posedge clk) ctrl.update_strobe_n <= 1'b0;
        exp[1] = 14'h0155;
        exp[2] = 14'h2aaa;
        repeat (8) @(negedge clk);
        checkAll();
    endtask : s_strobe
    // zero preset, a frame dropped under it, then a fresh load
    task automatic s_preset;
        @(posedge clk) ctrl <= 3'b000;
        repeat (8) @(negedge clk);
        exp = '0;
        checkAll();
        i_host.send({8'h5a, 2'h0, 14'h1111});
        repeat (10) @(negedge clk);
        checkAll();
        @(posedge clk) ctrl.preset_n <= 1'b1;
        repeat (8) @(negedge clk);
        checkAll();
        exp[3] = 14'h0777;
        load(2'h3, exp[3]);
        checkAll();
    endtask : s_preset
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (6) @(negedge clk);
        exp = {4{CODE_HALF}};
        checkAll();
        s_channels();
        s_strobe();
        s_preset();
        endSim();
    end
endmodule : qdsl_serial_load_tb_top
